/* File: core/motor_event_detect_filter.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// [R1] Tacho field zero: position or sensorless mode.
// [R2] Polarity bit set makes channel active low.
// [R3] Polarity ignored when phases are independent.
// [R4] Z event needs filter code plus one samples.
// [R5] Z samples at sampling clock or PWM.
// [R6] Sensorless D event blanks Z detection.
// [R7] Window length from table of code.
// [R8] Z sampling enable gates when outputs off.
// [R9] Software writes zero to reserved bits.
// [R10] Sampling clock 1 MHz down to 125 kHz.
// [R11] Encoder capture on clock tick or read.
// [R12] Input selection grounds or floats unused inputs.
// [R13] Filter register resets to 0fh, sampling zero.
// [R14] Sample counter restarts on miss or window.
module motor_event_detect_filter (
  // Clock and reset.
  input  wire logic                        clock,
  input  wire logic                        srst,
  // Register port.
  input  wire motor_detect_pkg::reg_req_t  req,
  output logic [7:0]                       rdata,
  // Pin side inputs, asynchronous to clock.
  input  wire logic                        z_pin,
  input  wire logic                        d_pin,
  input  wire logic                        tacho_pin,
  // Same-domain event inputs.
  input  wire logic                        pwm_tick,
  input  wire logic                        rtc_irq,
  input  wire logic                        timer_high_read,
  input  wire logic [5:0]                  phase_drive,
  // Outputs.
  output logic [5:0]                       phase_out,
  output logic                             z_event,
  output logic                             tacho_capture,
  output logic                             encoder_capture,
  output logic                             ground_unused_sense
);

  // Complete state of the block. One packed struct keeps every flip-flop in one place,
  // so the reset branch and the register update below cannot drift apart.
  typedef struct packed {
    // Tacho edge code; zero selects position sensor or sensorless use.
    logic [1:0]  tacho_edge_select;
    // Per-channel polarity; a set bit drives that channel active low.
    logic [5:0]  out_polarity;
    // Filter setting: consecutive Z samples needed, minus one.
    logic [3:0]  z_consecutive_count;
    // Blanking window code applied after each D event in sensorless mode.
    logic [3:0]  z_blanking_length;
    // Z sampling enable, effective while the motor outputs are off.
    logic        z_sampling_enable;
    // Sampling clock code.
    logic [1:0]  sampling_clock_sel;
    // Encoder capture trigger: real-time clock or timer high byte read.
    logic        encoder_capture_source;
    // Set leaves unused rotor sense inputs floating instead of grounded.
    logic        unused_input_float;
    // Three phases driven independently; polarity is then ignored.
    logic        independent_phase_config;
    // Sensor mode; no blanking window follows a D event.
    logic        sensor_mode_select;
    // Motor outputs enabled; Z sampling then runs whatever the enable bit says.
    logic        motor_output_enable;
    // Z samples taken on the PWM strobe instead of the sampling clock.
    logic        z_at_pwm_rate;
    // Sampling clock prescaler.
    logic [6:0]  presc;
    // Remaining blanking cycles; zero means Z detection is open.
    logic [10:0] blank;
    // Consecutive valid Z samples seen so far.
    logic [3:0]  z_run_count;
    // Two-stage synchronisers for the pin inputs.
    logic [1:0]  z_sync;
    logic [1:0]  d_sync;
    logic [1:0]  t_sync;
    // Previous synchronised levels, for edge detection; they reset to the idle level.
    logic        d_prev;
    logic        t_prev;
    // Registered outputs.
    logic [7:0]  rdata;
    logic        z_event;
    logic        tacho_cap;
    logic        enc_cap;
    logic [5:0]  phase_out;
    logic        ground;
  } state_t;

  state_t st_reg;   // Registered state.
  state_t st_next;  // Next state.

  // Blanking window length in clock cycles for a window code. Short codes step finely,
  // long codes start from a base and step coarsely, so four bits span a wide range.
  function automatic logic [10:0] win_cycles(input logic [3:0] code);
    int n;
    if (!code[3]) begin
      // Short windows: one fine step per code, the first step included.
      n = (int'(code) + 1) * motor_detect_pkg::WIN_STEP_CYC;
    end else begin
      // Long windows: a base plus coarse steps.
      n = motor_detect_pkg::WIN_LBASE_CYC
        + (int'(code) - 8) * motor_detect_pkg::WIN_LSTEP_CYC;
    end
    // The longest window fits eleven bits at the present clock.
    return n[10:0];
  endfunction

  // Sampling clock period in clock cycles, minus one, for a code. Each code doubles
  // the period, and the longest period still fits the seven-bit prescaler.
  function automatic logic [6:0] samp_last(input logic [1:0] code);
    int n;
    n = (motor_detect_pkg::SAMP_BASE_CYC << code) - 1;
    return n[6:0];
  endfunction

  logic samp_tick;    // One cycle per sampling clock period.
  logic sample_go;    // A Z sample is taken this cycle.
  logic d_rise;       // Synchronised D event edge.
  logic t_edge;       // Selected tacho edge.

  // Next state; all register writes and the detection datapath.
  always_comb begin
    st_next = st_reg;
    // Pin synchronisers; the first stage feeds only the second, so a metastable
    // first stage never reaches the edge detectors or the filter.
    st_next.z_sync = {st_reg.z_sync[0], z_pin};
    st_next.d_sync = {st_reg.d_sync[0], d_pin};
    st_next.t_sync = {st_reg.t_sync[0], tacho_pin};
    st_next.d_prev = st_reg.d_sync[1];
    st_next.t_prev = st_reg.t_sync[1];

    // Register writes. Reserved sampling bits are dropped, so they always read zero.
    if (req.wr) begin
      unique case (req.addr)
        motor_detect_pkg::OFS_PARITY: begin
          // Tacho edge code above six polarity bits.
          st_next.tacho_edge_select =
            req.wdata[motor_detect_pkg::EDGE_SEL_LSB +: 2];
          st_next.out_polarity = req.wdata[5:0];
        end
        motor_detect_pkg::OFS_ZFILTER: begin
          // Sample count above window length.
          st_next.z_consecutive_count = req.wdata[motor_detect_pkg::ZCOUNT_LSB +: 4];
          st_next.z_blanking_length   = req.wdata[3:0];
        end
        motor_detect_pkg::OFS_SAMPLING: begin
          // Enable, clock code, capture source and input float bit.
          st_next.z_sampling_enable =
            req.wdata[motor_detect_pkg::ZSAMPLE_EN_BIT];
          st_next.sampling_clock_sel =
            req.wdata[motor_detect_pkg::SAMP_CLK_LSB +: 2];
          st_next.encoder_capture_source =
            req.wdata[motor_detect_pkg::ENC_SRC_BIT];
          st_next.unused_input_float = req.wdata[motor_detect_pkg::FLOAT_BIT];
        end
        motor_detect_pkg::OFS_MODE: begin
          // Operating mode bits that the rest of the controller would own.
          st_next.independent_phase_config =
            req.wdata[motor_detect_pkg::INDEP_BIT];
          st_next.sensor_mode_select  = req.wdata[motor_detect_pkg::SENSOR_BIT];
          st_next.motor_output_enable = req.wdata[motor_detect_pkg::OUT_EN_BIT];
          st_next.z_at_pwm_rate       = req.wdata[motor_detect_pkg::ZPWM_BIT];
        end
        default: begin
          // Status and unmapped offsets ignore writes.
        end
      endcase
    end

    // Read data stands only in the cycle after the read strobe, and is zero otherwise.
    st_next.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        motor_detect_pkg::OFS_PARITY: begin
          // Tacho edge code and polarity bits.
          st_next.rdata = {st_reg.tacho_edge_select, st_reg.out_polarity};
        end
        motor_detect_pkg::OFS_ZFILTER: begin
          // Filter count and window length.
          st_next.rdata = {st_reg.z_consecutive_count, st_reg.z_blanking_length};
        end
        motor_detect_pkg::OFS_SAMPLING: begin
          // Reserved bits read as zero.
          st_next.rdata = {st_reg.z_sampling_enable, 3'h0, st_reg.sampling_clock_sel,
                           st_reg.encoder_capture_source, st_reg.unused_input_float};
        end
        motor_detect_pkg::OFS_MODE: begin
          // Mode bits in the low nibble.
          st_next.rdata = {4'h0, st_reg.z_at_pwm_rate, st_reg.motor_output_enable,
                           st_reg.sensor_mode_select, st_reg.independent_phase_config};
        end
        motor_detect_pkg::OFS_STATUS: begin
          // Sample count, speed sensor mode flag and blanking flag.
          st_next.rdata = {st_reg.z_run_count, 2'h0,
                           st_reg.tacho_edge_select != 2'h0,
                           st_reg.blank != 11'h000};
        end
        default: begin
          // Unmapped offsets read zero.
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // Sampling clock prescaler; restarts whenever it passes the period, so a change
    // of clock code mid-period takes effect at the next tick at the latest.
    samp_tick = (st_reg.presc >= samp_last(st_reg.sampling_clock_sel));  // [R10]
    st_next.presc = samp_tick ? 7'h00 : st_reg.presc + 7'h01;

    // Sample source and gating by the output enable.
    sample_go = (st_reg.z_at_pwm_rate ? pwm_tick : samp_tick)  // [R5]
              && (st_reg.motor_output_enable || st_reg.z_sampling_enable);  // [R8]

    // D event opens a blanking window only in sensorless mode.
    d_rise = st_reg.d_sync[1] && !st_reg.d_prev;
    st_next.z_event = 1'b0;
    if (st_reg.sensor_mode_select) begin
      // Sensor mode: no window, and any window in progress is dropped.
      st_next.blank = 11'h000;  // [R6]
    end else if (st_reg.blank != 11'h000) begin
      // Window in progress counts down.
      st_next.blank = st_reg.blank - 11'h001;
    end
    if (d_rise && !st_reg.sensor_mode_select) begin
      // New window; a partial run of samples before it is discarded.
      st_next.blank       = win_cycles(st_reg.z_blanking_length);  // [R6] [R7]
      st_next.z_run_count = 4'h0;                                  // [R14]
    end else if (sample_go && st_reg.blank == 11'h000) begin
      if (!st_reg.z_sync[1]) begin
        // A miss breaks the run of consecutive samples.
        st_next.z_run_count = 4'h0;  // [R14]
      end else if (st_reg.z_run_count == st_reg.z_consecutive_count) begin
        // Last sample of the run: one event, then a fresh run is needed.
        st_next.z_event     = 1'b1;  // [R4]
        st_next.z_run_count = 4'h0;
      end else begin
        // Run continues.
        st_next.z_run_count = st_reg.z_run_count + 4'h1;
      end
    end

    // Tacho capture edges in speed sensor modes only.
    unique case (motor_detect_pkg::tacho_edge_t'(st_reg.tacho_edge_select))  // [R1]
      motor_detect_pkg::EDGE_NONE: t_edge = 1'b0;
      motor_detect_pkg::EDGE_RISE: t_edge = st_reg.t_sync[1] && !st_reg.t_prev;
      motor_detect_pkg::EDGE_FALL: t_edge = !st_reg.t_sync[1] && st_reg.t_prev;
      motor_detect_pkg::EDGE_BOTH: t_edge = st_reg.t_sync[1] != st_reg.t_prev;
    endcase
    st_next.tacho_cap = t_edge;

    // Encoder capture source; meaningful in speed sensor modes only.
    st_next.enc_cap = (st_reg.tacho_edge_select != 2'h0)
                   && (st_reg.encoder_capture_source ? timer_high_read : rtc_irq);  // [R11]

    // Output polarity, bypassed for independent phases. The one-cycle latency is
    // the price of every output coming from a flip-flop.
    if (st_reg.independent_phase_config) begin
      st_next.phase_out = phase_drive;  // [R3]
    end else begin
      st_next.phase_out = phase_drive ^ st_reg.out_polarity;  // [R2]
    end

    // Unused sense inputs grounded only in plain sensorless mode.
    st_next.ground = !st_reg.independent_phase_config && st_reg.tacho_edge_select == 2'h0
                  && !st_reg.sensor_mode_select && !st_reg.unused_input_float;  // [R12]
  end

  // State register with synchronous reset. Only the filter register has a non-zero
  // reset value; everything else, outputs included, starts at zero.
  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg                     <= '0;
      st_reg.z_consecutive_count <= motor_detect_pkg::ZFILTER_RST[7:4];  // [R13]
      st_reg.z_blanking_length   <= motor_detect_pkg::ZFILTER_RST[3:0];  // [R13]
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign rdata               = st_reg.rdata;
  assign phase_out           = st_reg.phase_out;
  assign z_event             = st_reg.z_event;
  assign tacho_capture       = st_reg.tacho_cap;
  assign encoder_capture     = st_reg.enc_cap;
  assign ground_unused_sense = st_reg.ground;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Filter and sampling registers come out of reset with their documented values.
  a_reset_values: assert property ($past(srst) |->  // [R13]
    st_reg.z_consecutive_count == 4'h0 && st_reg.z_blanking_length == 4'hf
    && st_reg.sampling_clock_sel == 2'h0 && !st_reg.z_sampling_enable)
    else $error("Filter or sampling reset value wrong.");
  // No tacho capture in position sensor or sensorless use.
  a_tacho_off: assert property (tacho_capture |->  // [R1]
    $past(st_reg.tacho_edge_select) != 2'h0)
    else $error("Tacho capture in position mode.");
  // Polarity applied per channel when phases are coupled.
  a_polarity_xor: assert property (!$past(st_reg.independent_phase_config) |->  // [R2]
    phase_out == ($past(phase_drive) ^ $past(st_reg.out_polarity)))
    else $error("Polarity not applied.");
  // Polarity ignored when phases are independent.
  a_polarity_bypass: assert property ($past(st_reg.independent_phase_config) |->  // [R3]
    phase_out == $past(phase_drive))
    else $error("Polarity applied with independent phases.");
  // An event only after the full run of valid samples.
  a_filter_count: assert property (z_event |->  // [R4]
    $past(st_reg.z_run_count) == $past(st_reg.z_consecutive_count)
    && $past(st_reg.z_sync[1]))
    else $error("Z event without full sample count.");
  // No event while a window is open.
  a_blank_hold: assert property (z_event |-> $past(st_reg.blank) == 11'h000)  // [R6]
    else $error("Z event inside blanking window.");
  // The window starts with the length its code gives.
  a_window_len: assert property (d_rise && !st_reg.sensor_mode_select |=>  // [R7]
    st_reg.blank == win_cycles($past(st_reg.z_blanking_length)))
    else $error("Blanking window length wrong.");
  // No event while sampling is disabled.
  a_sample_gate: assert property (z_event |->  // [R8]
    $past(st_reg.motor_output_enable) || $past(st_reg.z_sampling_enable))
    else $error("Z event while sampling disabled.");
  // Prescaler stays within the selected period, except just after a code change.
  a_prescale_range: assert property (st_reg.presc <= samp_last(st_reg.sampling_clock_sel)
    || $past(st_reg.sampling_clock_sel) != st_reg.sampling_clock_sel)  // [R10]
    else $error("Sampling prescaler out of range.");
  // Encoder capture follows the selected trigger only.
  a_encoder_src: assert property (encoder_capture |->  // [R11]
    ($past(st_reg.encoder_capture_source) ? $past(timer_high_read) : $past(rtc_irq)))
    else $error("Encoder capture from wrong source.");
  // Grounding only with coupled phases, sensor mode off and the float bit clear.
  a_ground_sel: assert property (ground_unused_sense |->  // [R12]
    !$past(st_reg.independent_phase_config) && !$past(st_reg.sensor_mode_select)
    && !$past(st_reg.unused_input_float))
    else $error("Unused inputs grounded outside sensorless mode.");
  // A missed sample restarts the run.
  a_count_restart: assert property (sample_go && st_reg.blank == 11'h000  // [R14]
    && !st_reg.z_sync[1] && !d_rise |=> st_reg.z_run_count == 4'h0)
    else $error("Sample counter did not restart.");

  // Main scenarios: longest filter, longest window, both tacho edges, read capture.
  c_z_event: cover property (z_event && $past(st_reg.z_consecutive_count) == 4'hf);
  c_blank_long: cover property (d_rise && st_reg.z_blanking_length == 4'hf);
  c_tacho_both: cover property (tacho_capture && st_reg.tacho_edge_select == 2'h3);
  c_enc_read: cover property (encoder_capture && st_reg.encoder_capture_source);

endmodule // motor_event_detect_filter

/* File: core/motor_detect_pkg.sv */
package motor_detect_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] OFS_PARITY   = 3'h0;
  localparam logic [2:0] OFS_ZFILTER  = 3'h1;
  localparam logic [2:0] OFS_SAMPLING = 3'h2;
  localparam logic [2:0] OFS_MODE     = 3'h3;
  localparam logic [2:0] OFS_STATUS   = 3'h4;

  // Reset values.
  localparam logic [7:0] PARITY_RST   = 8'h00;
  localparam logic [7:0] ZFILTER_RST  = 8'h0f;
  localparam logic [7:0] SAMPLING_RST = 8'h00;
  localparam logic [7:0] MODE_RST     = 8'h00;

  // Field positions.
  localparam int EDGE_SEL_LSB   = 6;
  localparam int ZCOUNT_LSB     = 4;
  localparam int ZSAMPLE_EN_BIT = 7;
  localparam int SAMP_CLK_LSB   = 2;
  localparam int ENC_SRC_BIT    = 1;
  localparam int FLOAT_BIT      = 0;
  localparam int INDEP_BIT      = 0;
  localparam int SENSOR_BIT     = 1;
  localparam int OUT_EN_BIT     = 2;
  localparam int ZPWM_BIT       = 3;

  // Writable mask of the sampling register; bits 6:4 stay zero.
  localparam logic [7:0] SAMPLING_WMASK = 8'h8f;

  // Timing, with times given for the 10 MHz reference peripheral clock.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SAMP_BASE_NS    = 1000;
  localparam int WIN_STEP_NS     = 5000;
  localparam int WIN_LONG_BASE_NS = 60000;
  localparam int WIN_LONG_STEP_NS = 20000;
  localparam int SAMP_BASE_CYC   = SAMP_BASE_NS / CLK_PERIOD_NS;
  localparam int WIN_STEP_CYC    = WIN_STEP_NS / CLK_PERIOD_NS;
  localparam int WIN_LBASE_CYC   = WIN_LONG_BASE_NS / CLK_PERIOD_NS;
  localparam int WIN_LSTEP_CYC   = WIN_LONG_STEP_NS / CLK_PERIOD_NS;

  // Tacho edge selection codes.
  typedef enum logic [1:0] {
    EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH
  } tacho_edge_t;

  // Register write and read request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

endpackage

/* File: bench/rotor_sense_model.sv */
`timescale 1ns/1ps
// Pin-side stand-in for the rotor sensors. Levels reach the pins with a skew that has
// no relation to the clock, as real comparator and sensor edges would.
module rotor_sense_model (
  // Levels requested by the bench.
  input  wire logic z_want,
  input  wire logic d_want,
  input  wire logic t_want,
  // Pin levels toward the block.
  output wire logic z_pin,
  output wire logic d_pin,
  output wire logic tacho_pin
);
  // Zero-cross comparator, high while a valid Z sample is present.
  assign #37 z_pin = z_want;
  // D event source; each rising level opens a blanking window in the block unless sensor mode is set.
  assign #41 d_pin = d_want;
  // Tacho generator level.
  assign #23 tacho_pin = t_want;
endmodule // rotor_sense_model

/* File: bench/motor_event_detect_filter_tb.sv */
`timescale 1ns/1ps
module motor_event_detect_filter_tb;
  logic                       clock = 0;
  logic                       srst = 1;
  motor_detect_pkg::reg_req_t req = '0;
  logic [7:0]                 rdata, v;
  logic                       z_want = 0, d_want = 0, t_want = 0;
  wire logic                  z_pin, d_pin, tacho_pin;
  logic                       pwm_tick = 0, rtc_irq = 0, timer_high_read = 0;
  logic [5:0]                 phase_drive = '0, phase_out;
  logic                       z_event, tacho_capture, encoder_capture, ground_unused_sense;
  logic                       rd_q = 0;
  logic [7:0]                 exp_q[$];
  int                         mismatches = 0, compares = 0, cycles = 0, seed = 23679;
  int                         zcount = 0, tcount = 0, ecount = 0, t, w;
  int                         codes[4] = '{0, 7, 8, 15};

  motor_event_detect_filter motor_event_detect_filter_inst (.clock(clock), .srst(srst),
    .req(req), .rdata(rdata), .z_pin(z_pin), .d_pin(d_pin), .tacho_pin(tacho_pin),
    .pwm_tick(pwm_tick), .rtc_irq(rtc_irq), .timer_high_read(timer_high_read),
    .phase_drive(phase_drive), .phase_out(phase_out), .z_event(z_event),
    .tacho_capture(tacho_capture), .encoder_capture(encoder_capture),
    .ground_unused_sense(ground_unused_sense));
  rotor_sense_model rotor_sense_model_inst (.z_want(z_want), .d_want(d_want), .t_want(t_want),
    .z_pin(z_pin), .d_pin(d_pin), .tacho_pin(tacho_pin));

  // Free-running clock, 100 ns period.
  always #50 clock = ~clock;

  // Remembers which cycle carries read data.
  always @(posedge clock) rd_q <= req.rd;

  // Outputs are judged at the falling edge, where they have settled; event pulses are counted.
  always @(negedge clock) begin
    if (rd_q)
      check(rdata, exp_q.pop_front());
    if (z_event === 1'b1) zcount++;
    if (tacho_capture === 1'b1) tcount++;
    if (encoder_capture === 1'b1) ecount++;
  end

  // A hang is cut short well beyond the few thousand cycles the tests need.
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One write cycle; the strobe drops at the next edge so tasks never overlap.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  // One read cycle; the expected value is queued for the monitor.
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    exp_q.push_back(e);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
  endtask

  // One-cycle pulse on {timer_high_read, rtc_irq, pwm_tick}, then time for the answer.
  task automatic strobe(input logic [2:0] m);
    @(posedge clock);
    {timer_high_read, rtc_irq, pwm_tick} <= m;
    @(posedge clock);
    {timer_high_read, rtc_irq, pwm_tick} <= 3'h0;
    repeat (2) @(posedge clock);
  endtask

  // Counts falling edges until z_event is seen high, bounded beyond the longest window.
  task automatic wait_z(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (z_event !== 1'b1 && n < 3000);
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rd(motor_detect_pkg::OFS_ZFILTER, 8'h0f);
    rd(motor_detect_pkg::OFS_SAMPLING, 8'h00);
    rd(3'h7, 8'h00);
    check(ground_unused_sense, 1);
    wr(motor_detect_pkg::OFS_SAMPLING, 8'h8f);
    rd(motor_detect_pkg::OFS_SAMPLING, 8'h8f);
    repeat (2) @(negedge clock);
    check(ground_unused_sense, 0);
    wr(motor_detect_pkg::OFS_SAMPLING, 8'h00);
    $display("test done: registers");
    // Random polarity masks against random drive patterns.
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wr(motor_detect_pkg::OFS_PARITY, {2'b00, v[5:0]});
      phase_drive <= 6'($random(seed));
      repeat (2) @(negedge clock);
      check(phase_out, phase_drive ^ v[5:0]);
    end
    wr(motor_detect_pkg::OFS_MODE, 8'h01);
    repeat (2) @(negedge clock);
    check(phase_out, phase_drive);
    $display("test done: polarity");
    // Z filter at PWM rate: the event needs exactly code plus one high samples.
    z_want <= 1'b1;
    wr(motor_detect_pkg::OFS_MODE, 8'h0c);
    for (int k = 0; k < 16; k += 5) begin
      wr(motor_detect_pkg::OFS_ZFILTER, {k[3:0], 4'h0});
      t = zcount;
      repeat (k) strobe(3'b001);
      check(zcount - t, 0);
      strobe(3'b001);
      check(zcount - t, 1);
    end
    // Outputs off: sampling hangs on the enable bit alone.
    wr(motor_detect_pkg::OFS_MODE, 8'h08);
    wr(motor_detect_pkg::OFS_ZFILTER, 8'h00);
    t = zcount;
    strobe(3'b001);
    check(zcount - t, 0);
    wr(motor_detect_pkg::OFS_SAMPLING, 8'h80);
    strobe(3'b001);
    check(zcount - t, 1);
    $display("test done: z filter");
    // Sampling clock rate seen as the spacing of single-sample events.
    wr(motor_detect_pkg::OFS_MODE, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wr(motor_detect_pkg::OFS_SAMPLING, {4'h0, s[1:0], 2'b00});
      repeat (3) wait_z(t);
      check(t, motor_detect_pkg::SAMP_BASE_CYC << s);
    end
    wr(motor_detect_pkg::OFS_SAMPLING, 8'h00);
    // Blanking after a D event, kicked just after an event so the next tick is far off.
    foreach (codes[i]) begin
      w = codes[i] < 8 ? (codes[i] + 1) * motor_detect_pkg::WIN_STEP_CYC :
          motor_detect_pkg::WIN_LBASE_CYC + (codes[i] - 8) * motor_detect_pkg::WIN_LSTEP_CYC;
      wr(motor_detect_pkg::OFS_ZFILTER, {4'h0, 4'(codes[i])});
      wait_z(t);
      d_want <= 1'b1;
      wait_z(t);
      d_want <= 1'b0;
      check(t >= w && t <= w + 20, 1);
    end
    wr(motor_detect_pkg::OFS_MODE, 8'h06);
    wait_z(t);
    d_want <= 1'b1;
    wait_z(t);
    d_want <= 1'b0;
    check(t <= 20, 1);
    $display("test done: blanking");
    // Every tacho edge code: rising edges count for bit 0, falling for bit 1.
    for (int s = 0; s < 4; s++) begin
      wr(motor_detect_pkg::OFS_PARITY, {s[1:0], 6'h00});
      t = tcount;
      t_want <= 1'b1;
      repeat (8) @(negedge clock);
      check(tcount - t, s[0]);
      t_want <= 1'b0;
      repeat (8) @(negedge clock);
      check(tcount - t, s[0] + s[1]);
    end
    // Encoder capture source in both settings.
    for (int s = 0; s < 2; s++) begin
      wr(motor_detect_pkg::OFS_SAMPLING, {6'h00, s[0], 1'b0});
      t = ecount;
      strobe(3'b010);
      check(ecount - t, !s[0]);
      strobe(3'b100);
      check(ecount - t, 1);
    end
    // Status shows speed sensor mode and no open window; the read lands before the end.
    rd(motor_detect_pkg::OFS_STATUS, 8'h02);
    repeat (2) @(posedge clock);
    $display("test done: tacho and encoder");
    report_and_stop();
  end
endmodule // motor_event_detect_filter_tb
